/* File: hw/sarseq_top.sv */
// sarseq_top: sequencer, pacing timer, rotation and sample fifo.
// assumes the analogue core holds data and error stable near the end
// of each 96-cycle conversion; all on clk_i.
//
// The implementer's own choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
module sarseq_top
   import sarseq_pkg::*;
#(
   parameter int DW = 12
) (
   input  wire logic          clk_i,
   input  wire logic          rst_i,
   input  wire logic          ce_i,
   input  wire logic          wb_cyc_i,
   input  wire logic          wb_stb_i,
   input  wire logic          wb_we_i,
   input  wire logic [7:0]    wb_adr_i,
   input  wire logic [3:0]    wb_sel_i,
   input  wire logic [31:0]   wb_dat_i,
   output logic      [31:0]   wb_dat_o,
   output logic               wb_ack_o,
   input  wire logic [DW-1:0] sar_data_i,
   input  wire logic          sar_err_i,
   output logic               sar_power_o,
   output logic               sar_start_o,
   output logic      [2:0]    sar_chan_o,
   output logic               thermal_bias_o,
   output logic               dma_req_o,
   output logic               irq_o
);
   // ---- functions ----
   // byte-lane merge of a write onto the current value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
                                        input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) r[i*8 +: 8] = dat[i*8 +: 8];
      end
      return r;
   endfunction
   // next set mask bit after cur, cyclic over five inputs
   function automatic logic [2:0] next_chan(input logic [2:0] cur, input logic [4:0] m);
      logic [2:0] r;
      logic [2:0] c;
      r = cur;
      c = cur;
      for (int k = 0; k < NCHAN; k++) begin
         c = (c == 3'(NCHAN - 1)) ? 3'h0 : 3'(c + 3'h1);
         if (m[c] && r == cur && k < NCHAN) r = c;
      end
      // loop above keeps the first hit whether or not cur itself is set; the loop below finds the same one
      for (int k = NCHAN - 1; k >= 0; k--) begin
         if (m[3'((int'(cur) + 1 + k) % NCHAN)]) r = 3'((int'(cur) + 1 + k) % NCHAN);
      end
      return r;
   endfunction

   // ---- state ----
   sarseq_state_t         state;
   logic [6:0]            cnv_cnt;
   logic [2:0]            pwr_cnt;
   logic                  conv_on, bias_on, many_go;
   logic [2:0]            pick;
   logic [4:0]            rot_mask;
   logic [DW-1:0]         latest;
   logic                  last_err;
   logic                  fifo_en, byte_pack, err_tag, dma_request_allow, lost;
   logic [3:0]            fifo_level_trigger;
   logic [15:0]           pace_int;
   logic [7:0]            pace_frac, pace_acc;
   logic [16:0]           pace_cnt;
   logic                  irq_mask_bits, intf;
   logic [DW:0]           sar_s1, sar_s2;
   logic [DW:0]           fifo_mem [FIFO_DEPTH];
   logic [2:0]            wr_ptr, rd_ptr;
   logic [3:0]            level;

   // ---- bus decode ----
   logic        req, wr, rd, w_cs, w_fcs, w_div, w_irq_mask_bits, w_intf, pop, push, full, empty;
   logic [31:0] cs_view, fcs_view, cs_new, fcs_new, div_new;
   assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr     = req & wb_we_i;
   assign rd     = req & ~wb_we_i;
   assign w_cs   = wr && wb_adr_i == OFS_CS;
   assign w_fcs  = wr && wb_adr_i == OFS_FCS;
   assign w_div  = wr && wb_adr_i == OFS_DIV;
   assign w_irq_mask_bits = wr && wb_adr_i == OFS_IRQ_MASK_BITS;
   assign w_intf = wr && wb_adr_i == OFS_INTF;
   assign full   = level == 4'(FIFO_DEPTH);
   assign empty  = level == 4'h0;
   assign pop    = rd && wb_adr_i == OFS_FIFO && !empty;

   // status views; reserved bits read zero
   always_comb begin
      cs_view = 32'h0;
      cs_view[CS_ON]   = conv_on;
      cs_view[CS_BIAS] = bias_on;
      cs_view[CS_MANY] = many_go;
      cs_view[CS_IDLE] = state == ST_IDLE;
      cs_view[CS_ERR]  = last_err;
      cs_view[CS_PICK +: 3] = pick;
      cs_view[CS_ROT +: 5]  = rot_mask;
      fcs_view = 32'h0;
      fcs_view[FCS_EN]    = fifo_en;
      fcs_view[FCS_SHIFT] = byte_pack;
      fcs_view[FCS_ETAG]  = err_tag;
      fcs_view[FCS_DREQ]  = dma_request_allow;
      fcs_view[FCS_EMPTY] = empty;
      fcs_view[FCS_FULL]  = full;
      fcs_view[FCS_LOST]  = lost;
      fcs_view[FCS_LVL +: 4] = level;
      fcs_view[FCS_THR +: 4] = fifo_level_trigger;
   end
   assign cs_new  = merge(cs_view, wb_dat_i, wb_sel_i);
   assign fcs_new = merge(fcs_view, wb_dat_i, wb_sel_i);
   assign div_new = merge({8'h0, pace_int, pace_frac}, wb_dat_i, wb_sel_i);

   // ---- analogue inputs pass two flops ----
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sar_s1 <= '0;
         sar_s2 <= '0;
      end else if (ce_i) begin
         sar_s1 <= {sar_err_i, sar_data_i};
         sar_s2 <= sar_s1;
      end
   end

   // ---- pacing and sequencing terms ----
   logic       div_zero, pace_tick, once, done, restart, start_now, at_thr, raw;
   logic [8:0] acc_sum;
   logic [2:0] pick_nx, pick_wr;
   assign div_zero  = pace_int == 16'h0;
   assign pace_tick = many_go && pace_cnt == 17'h0;
   assign acc_sum   = {1'b0, pace_acc} + {1'b0, pace_frac};
   assign once      = w_cs && cs_new[CS_ONCE];
   assign done      = state == ST_CONV && cnv_cnt == 7'(CONV_CYCLES - 1);
   // no pacing: the next sample starts straight from the finish
   assign restart   = done && conv_on && many_go && div_zero;
   assign start_now = once || (many_go && (div_zero || pace_tick));
   assign pick_nx   = (rot_mask != 5'h0) ? next_chan(pick, rot_mask) : pick;
   assign pick_wr   = (cs_new[CS_PICK +: 3] > 3'h4) ? 3'h4 : cs_new[CS_PICK +: 3];

   // pacing divider; count restarts on any write of the fields
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pace_int  <= RST_INT;
         pace_frac <= RST_FRAC;
         pace_cnt  <= 17'h0;
         pace_acc  <= 8'h0;
      end else if (ce_i) begin
         if (w_div) begin
            pace_int  <= div_new[DIV_INT +: 16];
            pace_frac <= div_new[DIV_FRAC +: 8];
            pace_cnt  <= {1'b0, div_new[DIV_INT +: 16]};
            pace_acc  <= 8'h0;
         end else if (!many_go) begin
            pace_cnt <= {1'b0, pace_int};
            pace_acc <= 8'h0;
         end else if (pace_cnt == 17'h0) begin
            // carry out of the accumulator stretches one interval
            pace_acc <= acc_sum[7:0];
            pace_cnt <= {1'b0, pace_int} + {16'h0, acc_sum[8]};
         end else begin
            pace_cnt <= pace_cnt - 17'h1;
         end
      end
   end

   // control fields of the control/status register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         conv_on  <= 1'b0;
         bias_on  <= 1'b0;
         many_go  <= 1'b0;
         pick     <= RST_PICK;
         rot_mask <= 5'h0;
      end else if (ce_i) begin
         if (w_cs) begin
            conv_on  <= cs_new[CS_ON];
            bias_on  <= cs_new[CS_BIAS];
            many_go  <= cs_new[CS_MANY];
            // values above four are held off the mux
            pick     <= pick_wr;
            rot_mask <= cs_new[CS_ROT +: 5];
         end else if (done) begin
            pick <= pick_nx;
         end
      end
   end
   assign thermal_bias_o = bias_on;
   assign sar_power_o    = state != ST_OFF;

   // sequencer: off, warm-up, idle, converting
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state   <= ST_OFF;
         cnv_cnt <= 7'h0;
         pwr_cnt <= 3'h0;
      end else if (ce_i) begin
         case (state)
            ST_OFF: begin
               pwr_cnt <= 3'h0;
               if (conv_on) state <= ST_PWR;
            end
            ST_PWR: begin
               pwr_cnt <= pwr_cnt + 3'h1;
               if (!conv_on) state <= ST_OFF;
               else if (pwr_cnt == 3'(PWRUP_CYCLES - 1)) state <= ST_IDLE;
            end
            ST_IDLE: begin
               cnv_cnt <= 7'h0;
               if (!conv_on) state <= ST_OFF;
               else if (start_now) state <= ST_CONV;
            end
            ST_CONV: begin
               // triggers during a conversion are simply not looked at
               cnv_cnt <= cnv_cnt + 7'h1;
               if (!conv_on) state <= ST_OFF;
               else if (restart) cnv_cnt <= 7'h0;
               else if (done) state <= ST_IDLE;
            end
            default: state <= ST_OFF;
         endcase
      end
   end

   // start pulse and channel to the analogue core
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sar_start_o <= 1'b0;
         sar_chan_o  <= 3'h0;
      end else if (ce_i) begin
         sar_start_o <= (state == ST_IDLE && conv_on && start_now) || restart;
         if (state == ST_IDLE) sar_chan_o <= w_cs ? pick_wr : pick;
         else if (restart) sar_chan_o <= pick_nx;
      end
   end

   // latest result, taken when the period ends
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         latest   <= '0;
         last_err <= 1'b0;
      end else if (ce_i && done) begin
         latest   <= sar_s2[DW-1:0];
         last_err <= sar_s2[DW];
      end
   end

   // ---- sample fifo ----
   logic [DW:0] entry;
   assign push  = done && fifo_en;
   assign entry = {err_tag & sar_s2[DW],
                   byte_pack ? {4'h0, sar_s2[DW-1:4]} : sar_s2[DW-1:0]};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ptr <= 3'h0;
         rd_ptr <= 3'h0;
         level  <= 4'h0;
      end else if (ce_i) begin
         // a full fifo keeps its contents; the new sample is dropped
         if (push && !full) begin
            fifo_mem[wr_ptr] <= entry;
            wr_ptr <= wr_ptr + 3'h1;
         end
         if (pop) rd_ptr <= rd_ptr + 3'h1;
         level <= level + {3'h0, push && !full} - {3'h0, pop};
      end
   end

   // fifo control; lost flag set beats a same-cycle clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fifo_en   <= 1'b0;
         byte_pack <= 1'b0;
         err_tag   <= 1'b0;
         dma_request_allow   <= 1'b0;
         fifo_level_trigger    <= RST_FIFO_LEVEL_TRIGGER;
         lost      <= 1'b0;
         irq_mask_bits      <= 1'b0;
         intf      <= 1'b0;
      end else if (ce_i) begin
         if (w_fcs) begin
            fifo_en   <= fcs_new[FCS_EN];
            byte_pack <= fcs_new[FCS_SHIFT];
            err_tag   <= fcs_new[FCS_ETAG];
            dma_request_allow   <= fcs_new[FCS_DREQ];
            fifo_level_trigger    <= fcs_new[FCS_THR +: 4];
         end
         if (push && full) lost <= 1'b1;
         else if (w_fcs && wb_sel_i[1] && wb_dat_i[FCS_LOST]) lost <= 1'b0;
         if (w_irq_mask_bits) irq_mask_bits <= wb_dat_i[0];
         if (w_intf) intf <= wb_dat_i[0];
      end
   end

   // level-driven request and interrupt; no latch, so draining below the trigger clears dma_req_o, and irq_o while intf is clear
   assign at_thr    = level >= fifo_level_trigger;
   assign raw       = at_thr;
   assign dma_req_o = dma_request_allow && at_thr;
   assign irq_o     = (raw || intf) && irq_mask_bits;

   // ---- bus answer: one wait state, read data registered ----
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce_i) begin
         wb_ack_o <= req;
         if (rd) begin
            case (wb_adr_i)
               OFS_CS:   wb_dat_o <= cs_view;
               OFS_RES:  wb_dat_o <= {20'h0, latest};
               OFS_FCS:  wb_dat_o <= fcs_view;
               OFS_FIFO: wb_dat_o <= empty ? 32'h0 :
                                     {16'h0, fifo_mem[rd_ptr][DW], 3'h0, fifo_mem[rd_ptr][DW-1:0]};
               OFS_DIV:  wb_dat_o <= {8'h0, pace_int, pace_frac};
               OFS_INTR: wb_dat_o <= {31'h0, raw};
               OFS_IRQ_MASK_BITS: wb_dat_o <= {31'h0, irq_mask_bits};
               OFS_INTF: wb_dat_o <= {31'h0, intf};
               OFS_IRQ_MASKED_STATE: wb_dat_o <= {31'h0, irq_o};
               default:  wb_dat_o <= 32'h0;
            endcase
         end
      end
   end

   // ---- checks; frozen cycles are skipped ----
   default clocking cb @(posedge clk_i iff ce_i); endclocking
   default disable iff (rst_i);

   logic [17:0] gap;
   always_ff @(posedge clk_i) begin
      if (rst_i || w_div || !many_go) gap <= 18'h1;
      else if (ce_i) gap <= pace_tick ? 18'h1 : gap + 18'h1;
   end

   sequence s_start;
      state == ST_IDLE && conv_on && start_now;
   endsequence
   sequence s_warm;
      state == ST_OFF && conv_on;
   endsequence

   a_conv_length: assert property (s_start |-> ##96 (done || !conv_on))
      else $error("conversion length wrong");
   a_idle_return: assert property (done && !restart && conv_on |=> state == ST_IDLE)
      else $error("idle not back after conversion");
   a_warm_ready: assert property (s_warm ##1 conv_on[*4] |=> state == ST_IDLE)
      else $error("ready not raised after warm-up");
   a_off_stops: assert property (!conv_on |=> state == ST_OFF && !sar_start_o)
      else $error("converter still running while off");
   a_back_back: assert property (restart |=> state == ST_CONV && cnv_cnt == 7'h0 ##1 cnv_cnt == 7'h1)
      else $error("free run not back to back");
   a_pace_gap: assert property (pace_tick && !w_div && $past(many_go)
                                |-> gap >= 18'(pace_int) + 18'h1 && gap <= 18'(pace_int) + 18'h2)
      else $error("pacing interval out of range");
   a_rotate_pick: assert property (done && rot_mask != 5'h0 && !w_cs |=> rot_mask[pick])
      else $error("rotation picked unmasked input");
   a_fifo_drop: assert property (push && full && !pop |=> lost && level == $past(level))
      else $error("full fifo not protected");
   a_byte_pack: assert property (push && !full && byte_pack |=> fifo_mem[$past(wr_ptr)][11:8] == 4'h0)
      else $error("byte pack left high bits");
   a_dreq_rise: assert property ($rose(dma_req_o) |-> $past(push) || $past(w_fcs))
      else $error("request rose without cause");
   a_irq_drain: assert property ($fell(raw) |-> $past(pop) || $past(w_fcs))
      else $error("interrupt dropped above trigger");
endmodule // sarseq_top

/* File: hw/sarseq_pkg.sv */
// sarseq_pkg: constants shared by the converter sequencer.
// assumes a 32-bit classic wishbone slave, byte addresses in 8 bits.
package sarseq_pkg;
   localparam int CONV_CYCLES  = 96; // converter clocks per sample
   localparam int PWRUP_CYCLES = 4;  // analogue warm-up after enable
   localparam int FIFO_DEPTH   = 8;
   localparam int NCHAN        = 5;  // four pins plus thermal sensor
   // register byte offsets
   localparam logic [7:0] OFS_CS   = 8'h00;
   localparam logic [7:0] OFS_RES  = 8'h04;
   localparam logic [7:0] OFS_FCS  = 8'h08;
   localparam logic [7:0] OFS_FIFO = 8'h0c;
   localparam logic [7:0] OFS_DIV  = 8'h10;
   localparam logic [7:0] OFS_INTR = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK_BITS = 8'h18;
   localparam logic [7:0] OFS_INTF = 8'h1c;
   localparam logic [7:0] OFS_IRQ_MASKED_STATE = 8'h20;
   // control/status field positions
   localparam int CS_ON = 0, CS_BIAS = 1, CS_ONCE = 2, CS_MANY = 3;
   localparam int CS_IDLE = 8, CS_ERR = 9, CS_PICK = 12, CS_ROT = 16;
   // fifo control field positions
   localparam int FCS_EN = 0, FCS_SHIFT = 1, FCS_ETAG = 2, FCS_DREQ = 3;
   localparam int FCS_EMPTY = 8, FCS_FULL = 9, FCS_LOST = 10;
   localparam int FCS_LVL = 16, FCS_THR = 24;
   localparam int FIFO_ERR = 15;
   localparam int DIV_FRAC = 0, DIV_INT = 8;
   // values after reset
   localparam logic [3:0]  RST_FIFO_LEVEL_TRIGGER = 4'h0;
   localparam logic [2:0]  RST_PICK   = 3'h0;
   localparam logic [15:0] RST_INT    = 16'h0000;
   localparam logic [7:0]  RST_FRAC   = 8'h00;
   typedef enum logic [3:0] {
      ST_OFF  = 4'b0001,
      ST_PWR  = 4'b0010,
      ST_IDLE = 4'b0100,
      ST_CONV = 4'b1000
   } sarseq_state_t;
endpackage

/* File: sim/sarseq_core_model.sv */
// sarseq_core_model: behavioural analogue converter core.
// assumes one start pulse per conversion; answers with chan and count.
`timescale 1ns/1ps
module sarseq_core_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        power_i,
   input  wire logic        start_i,
   input  wire logic [2:0]  chan_i,
   output logic      [11:0] data_o,
   output logic             err_o
);
   logic       prev;
   logic [7:0] cnt;

   // result held from start to next start; unpowered lines wander
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev   <= 1'b0;
         cnt    <= 8'h00;
         data_o <= 12'h000;
         err_o  <= 1'b0;
      end else begin
         prev <= start_i;
         if (!power_i) begin
            data_o <= ~data_o; // no stale value while off
            err_o  <= ~err_o;
         end else if (start_i && !prev) begin
            data_o <= {chan_i, 1'b0, cnt};
            err_o  <= (chan_i == 3'd3); // channel 3 fails to converge
            cnt    <= cnt + 8'h01;
         end
      end
   end
endmodule // sarseq_core_model

/* File: sim/sarseq_top_tb.sv */
// sarseq_top_tb: register-level tests of the converter sequencer.
// assumes the core model on the far side and a wishbone classic master.
`timescale 1ns/1ps
module sarseq_top_tb;
   import sarseq_pkg::*;
   logic        clk_i    = 1'b0;
   logic        rst_i    = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i  = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, sar_power_o, sar_start_o, thermal_bias_o;
   logic        dma_req_o, irq_o, sar_err;
   logic [2:0]  sar_chan_o;
   logic [11:0] sar_data, e;
   logic [31:0] d;
   logic        st_prev = 1'b0;
   int          failures = 0;
   int          comparisons = 0;
   int          cyc = 0;
   int          n;
   int          st_cyc[$];
   logic [2:0]  st_ch[$];
   logic [2:0]  ord [9] = '{3'd0, 3'd1, 3'd3, 3'd1, 3'd3, 3'd1, 3'd3, 3'd1, 3'd3};

   always #20 clk_i = ~clk_i;

   sarseq_top uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sar_data_i(sar_data),
      .sar_err_i(sar_err), .sar_power_o(sar_power_o), .sar_start_o(sar_start_o),
      .sar_chan_o(sar_chan_o), .thermal_bias_o(thermal_bias_o), .dma_req_o(dma_req_o),
      .irq_o(irq_o));

   sarseq_core_model core (.clk_i(clk_i), .rst_i(rst_i), .power_i(sar_power_o),
      .start_i(sar_start_o), .chan_i(sar_chan_o), .data_o(sar_data), .err_o(sar_err));

   // log cycle and channel of every conversion start
   always @(posedge clk_i) begin
      cyc     <= cyc + 1;
      st_prev <= sar_start_o;
      if (sar_start_o === 1'b1 && st_prev !== 1'b1) begin
         st_cyc.push_back(cyc);
         st_ch.push_back(sar_chan_o);
      end
   end

   // result the core model gives for start number i
   function automatic logic [11:0] exp_data(int i);
      return {st_ch[i], 1'b0, i[7:0]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] expd);
      comparisons++;
      if (seen !== expd) begin
         failures++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, expd);
      end
   endtask

   // one classic cycle; held until ack is sampled high
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= v;
      wb_sel_i <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 40);
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (n >= 40) failures++;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      xfer(1'b1, a, v);
   endtask

   task automatic rd(input logic [7:0] a);
      xfer(1'b0, a, 32'h0);
   endtask

   // poll idle; a read takes about three cycles
   task automatic wait_idle;
      for (int k = 0; k < 200; k++) begin
         rd(OFS_CS);
         if (d[CS_IDLE] === 1'b1) break;
      end
      chk(d[CS_IDLE], 1'b1);
   endtask

   task automatic wait_starts(input int cnt);
      for (int k = 0; k < 4000 && st_cyc.size() < cnt; k++) @(posedge clk_i);
   endtask

   task print_verdict;
      if (failures == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // whole run is a few thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      print_verdict;
   end

   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(OFS_CS);
      chk(d, 32'h0);
      rd(OFS_FCS);
      chk(d[7:0], 8'h00);
      rd(8'h24);
      chk(d, 32'h0);
      wr(OFS_CS, 32'h1);
      wait_idle;
      chk(sar_power_o, 1'b1);
      chk(thermal_bias_o, 1'b0);
      wr(OFS_CS, 32'h3);
      chk(thermal_bias_o, 1'b1);
      // one-shot on the failing channel
      wr(OFS_CS, 32'h3005);
      rd(OFS_CS);
      chk(d[CS_IDLE], 1'b0);
      wait_idle;
      chk(d[CS_ERR], 1'b1);
      chk(st_ch[0], 3'd3);
      rd(OFS_RES);
      chk(d[11:0], exp_data(0));
      // free-running with rotation, fifo overfilled
      wr(OFS_IRQ_MASK_BITS, 32'h0);
      wr(OFS_FCS, 32'h0400000d);
      wr(OFS_CS, 32'h000a0009);
      wait_starts(10);
      wr(OFS_CS, 32'h1);
      wait_idle;
      for (int i = 1; i < 10; i++) begin
         chk(st_ch[i], ord[i-1]);
         if (i > 1) chk(st_cyc[i] - st_cyc[i-1], 96);
      end
      rd(OFS_RES);
      chk(d[11:0], exp_data(9));
      rd(OFS_FCS);
      chk(d[19:16], 4'h8);
      chk(d[10:8], 3'b110);
      chk(dma_req_o, 1'b1);
      chk(irq_o, 1'b0);
      wr(OFS_IRQ_MASK_BITS, 32'h1);
      chk(irq_o, 1'b1);
      rd(OFS_IRQ_MASKED_STATE);
      chk(d[0], 1'b1);
      for (int i = 0; i < 8; i++) begin
         rd(OFS_FIFO);
         chk(d[15:0], {st_ch[i+1] == 3'd3, 3'b000, exp_data(i+1)});
         if (i == 4) chk({dma_req_o, irq_o}, 2'b00);
      end
      rd(OFS_FCS);
      chk(d[10:8], 3'b101);
      rd(OFS_FIFO);
      chk(d, 32'h0);
      // byte packed one-shot, streaming set-up: trigger one, bytes packed
      wr(OFS_FCS, 32'h0100000b);
      wr(OFS_CS, 32'h1005);
      wait_idle;
      e = exp_data(10);
      chk(dma_req_o, 1'b1);
      rd(OFS_FIFO);
      chk(d[15:0], {8'h00, e[11:4]});
      chk(dma_req_o, 1'b0);
      // paced free-running, whole then fraction
      wr(OFS_FCS, 32'h0);
      wr(OFS_DIV, 32'h7800);
      wr(OFS_CS, 32'h9);
      wait_starts(15);
      chk(st_cyc[13] - st_cyc[12], 121);
      chk(st_cyc[14] - st_cyc[13], 121);
      wr(OFS_DIV, 32'h7880);
      n = st_cyc.size();
      wait_starts(n + 3);
      chk(st_cyc[n+2] - st_cyc[n], 243);
      // switch off mid-run: no further starts
      wr(OFS_CS, 32'h0);
      repeat (2) @(posedge clk_i);
      chk(sar_power_o, 1'b0);
      n = st_cyc.size();
      repeat (300) @(posedge clk_i);
      chk(st_cyc.size(), n);
      print_verdict;
   end
endmodule // sarseq_top_tb
